// File: dcar_regs.sv
// dcar_regs: ahb-lite register window for debug comparator match values.
// assumes a single-slave ahb-lite bus on hclk; cpu buses synchronous.
`timescale 1ns/1ps
`default_nettype none
module dcar_regs
    import dcar_pkg::*;
(
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  wire logic [ADDR_W-1:0]    cpu_addr,
    input  wire logic [DATA_W-1:0]    cpu_data,
    output logic      [NUM_CMP-1:0]   match,
    output logic                      armed
);
    dcar_cmp_if cif ();

    logic [1:0]            window_select_field;
    logic [7:0]            comparator_a_control;
    logic [ADDR_W-1:0]     caddr [NUM_CMP];
    logic [DATA_W-1:0]     cmp_data;
    logic [DATA_W-1:0]     cmp_mask;
    logic                  wr_pend;
    logic [IDX_W-1:0]      wr_idx;

    wire logic             take;
    wire logic [IDX_W-1:0] a_idx;
    wire logic             sel_cmp;
    wire logic             sel_a;
    wire logic             wr_ok_addr;
    wire logic             wr_ok_data;
    wire logic [1:0]       ws;
    logic [7:0]            rd_byte;

    assign take  = hsel && hready && (htrans == HTRANS_NONSEQ ||
                                      htrans == HTRANS_SEQ);
    assign a_idx = haddr[IDX_LSB +: IDX_W];
    assign ws    = window_select_field;
    assign sel_cmp = (ws != SEL_NONE);
    assign sel_a   = (ws == SEL_A);
    assign wr_ok_addr = sel_cmp && !armed;
    assign wr_ok_data = sel_a && !armed;

    // read mux for the address phase; data phase then returns it
    always_comb begin
        rd_byte = RST_BYTE;
        if (a_idx == IDX_CTRL_ONE) begin
            rd_byte = {armed, 5'h00, ws};
        end else if (a_idx == IDX_CMPA_CTRL) begin
            rd_byte = comparator_a_control;
        end else if (a_idx == IDX_ADDR_HIGH && sel_cmp) begin
            rd_byte = {6'h00, caddr[ws][17:16]};
        end else if (a_idx == IDX_ADDR_MID && sel_cmp) begin
            rd_byte = caddr[ws][15:8];
        end else if (a_idx == IDX_ADDR_LOW && sel_cmp) begin
            rd_byte = caddr[ws][7:0];
        end else if (a_idx == IDX_DATA_HIGH && sel_a) begin
            rd_byte = cmp_data[15:8];
        end else if (a_idx == IDX_DATA_LOW && sel_a) begin
            rd_byte = cmp_data[7:0];
        end else if (a_idx == IDX_DMASK_HIGH && sel_a) begin
            rd_byte = cmp_mask[15:8];
        end else if (a_idx == IDX_DMASK_LOW && sel_a) begin
            rd_byte = cmp_mask[7:0];
        end else if (a_idx == IDX_STATUS) begin
            rd_byte = {5'h00, match};
        end
    end

    // bus: zero wait, always okay; unmapped reads zero, writes dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend   <= 1'b0;
            wr_idx    <= '0;
            hrdata    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend <= take && hwrite;
            wr_idx  <= a_idx;
            hrdata  <= (take && !hwrite) ? {24'h000000, rd_byte} : '0;
        end
    end

    wire logic [7:0] wb;
    assign wb = hwdata[7:0];

    // control one: arm bit and window select
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            armed               <= 1'b0;
            window_select_field <= SEL_A;
        end else if (wr_pend && wr_idx == IDX_CTRL_ONE) begin
            armed               <= wb[ARM_BIT];
            window_select_field <= wb[SEL_MSB:0];
        end
    end

    // comparator a control shares the window base; only its tag bit is used
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            comparator_a_control <= RST_BYTE;
        end else if (wr_pend && wr_idx == IDX_CMPA_CTRL && wr_ok_data) begin
            comparator_a_control <= wb;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CMP; g++) begin : g_addr
            wire logic hit;
            assign hit = wr_pend && wr_ok_addr && (ws == 2'(g));
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    caddr[g] <= '0;
                end else if (hit && wr_idx == IDX_ADDR_HIGH) begin
                    caddr[g][17:16] <= wb[1:0] & ADDR_HIGH_MASK;
                end else if (hit && wr_idx == IDX_ADDR_MID) begin
                    caddr[g][15:8] <= wb;
                end else if (hit && wr_idx == IDX_ADDR_LOW) begin
                    caddr[g][7:0] <= wb;
                end
            end
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp_data <= '0;
            cmp_mask <= '0;
        end else if (wr_pend && wr_ok_data) begin
            if (wr_idx == IDX_DATA_HIGH) cmp_data[15:8] <= wb;
            if (wr_idx == IDX_DATA_LOW) cmp_data[7:0] <= wb;
            if (wr_idx == IDX_DMASK_HIGH) cmp_mask[15:8] <= wb;
            if (wr_idx == IDX_DMASK_LOW) cmp_mask[7:0] <= wb;
        end
    end

    assign cif.addr_a = caddr[0];
    assign cif.addr_b = caddr[1];
    assign cif.addr_c = caddr[2];
    assign cif.data_a = cmp_data;
    assign cif.mask_a = cmp_mask;
    assign cif.tag_a  = comparator_a_control[TAG_BIT];

    dcar_match u_match (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .cfg      (cif.cmp),
        .cpu_addr (cpu_addr),
        .cpu_data (cpu_data),
        .match    (match)
    );

    logic [ADDR_W-1:0] p_addr [NUM_CMP];
    assign p_addr = caddr;

    // a locked write must leave every stored match value untouched
    armed_blocks_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        armed && wr_pend |=> caddr[0] == $past(p_addr[0]) &&
        caddr[1] == $past(p_addr[1]) && caddr[2] == $past(p_addr[2]) &&
        cmp_data == $past(cmp_data) && cmp_mask == $past(cmp_mask))
        else $error("write changed registers while armed");
    none_write_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_pend && ws == SEL_NONE |=> caddr[0] == $past(p_addr[0]) &&
        caddr[1] == $past(p_addr[1]) && caddr[2] == $past(p_addr[2]))
        else $error("select 11 let an address write land");
    data_gate_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_pend && !sel_a |=> cmp_data == $past(cmp_data) &&
        cmp_mask == $past(cmp_mask))
        else $error("data write landed outside select 00");
    high_upper_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        take && !hwrite && a_idx == IDX_ADDR_HIGH |=> hrdata[7:2] == '0)
        else $error("address high upper bits not zero");
    none_read_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        take && !hwrite && ws == SEL_NONE && a_idx == IDX_ADDR_MID
        |=> hrdata == '0)
        else $error("select 11 exposed an address register");
    data_read_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        take && !hwrite && !sel_a && a_idx == IDX_DATA_LOW
        |=> hrdata == '0)
        else $error("data register read outside select 00");
    match_a_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cpu_addr != caddr[0] |=> !match[0])
        else $error("comparator a matched wrong address");
    mask_any_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cpu_addr == caddr[0] && cmp_mask == '0 |=> match[0])
        else $error("masked data blocked a match");
    tag_skip_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cpu_addr == caddr[0] && cif.tag_a |=> match[0])
        else $error("tag set still compared data");
    data_cmp_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !cif.tag_a && ((cpu_data ^ cmp_data) & cmp_mask) != '0
        |=> !match[0])
        else $error("unmasked data mismatch still matched");
    match_b_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cpu_addr == caddr[1] |=> match[1])
        else $error("comparator b address match missed");
    match_c_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cpu_addr == caddr[2] |=> match[2])
        else $error("comparator c address match missed");
    // b and c match on address alone, so any differing bit must miss
    addr_miss_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cpu_addr != caddr[1] && cpu_addr != caddr[2]
        |=> match[2:1] == 2'b00)
        else $error("comparator b or c matched wrong address");
    ready_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp)
        else $error("slave stalled or errored");
    arm_cov: cover property (@(posedge hclk) disable iff (!hresetn)
        $rose(armed));
    wr_addr_cov: cover property (@(posedge hclk) disable iff (!hresetn)
        wr_pend && wr_ok_addr && wr_idx == IDX_ADDR_LOW);
    match_cov: cover property (@(posedge hclk) disable iff (!hresetn)
        match[0] && cmp_mask != '0);
    blk_cov: cover property (@(posedge hclk) disable iff (!hresetn)
        wr_pend && armed);
    none_cov: cover property (@(posedge hclk) disable iff (!hresetn)
        take && ws == SEL_NONE);
endmodule : dcar_regs
`default_nettype wire

// File: dcar_pkg.sv
// dcar_pkg: offsets, field layouts and reset values for the comparator
// window. assumes a 32-bit ahb-lite slave, one register per aligned word.
package dcar_pkg;
    // printed offsets are register indices; byte address is four times
    localparam logic [7:0]  IDX_ADDR_HIGH   = 8'h29;
    localparam logic [7:0]  IDX_ADDR_MID    = 8'h2a;
    localparam logic [7:0]  IDX_ADDR_LOW    = 8'h2b;
    localparam logic [7:0]  IDX_DATA_HIGH   = 8'h2c;
    localparam logic [7:0]  IDX_DATA_LOW    = 8'h2d;
    localparam logic [7:0]  IDX_DMASK_HIGH  = 8'h2e;
    localparam logic [7:0]  IDX_DMASK_LOW   = 8'h2f;
    // own control registers
    localparam logic [7:0]  IDX_CTRL_ONE    = 8'h20;
    localparam logic [7:0]  IDX_CMPA_CTRL   = 8'h28;
    localparam logic [7:0]  IDX_STATUS      = 8'h30;
    localparam int          IDX_W           = 8;
    localparam int          IDX_LSB         = 2;
    localparam int          ADDR_W          = 18;
    localparam int          DATA_W          = 16;
    localparam int          NUM_CMP         = 3;
    localparam int          ARM_BIT         = 7;
    localparam int          TAG_BIT         = 5;
    localparam int          SEL_MSB         = 1;
    localparam logic [1:0]  SEL_A           = 2'h0;
    localparam logic [1:0]  SEL_NONE        = 2'h3;
    localparam logic [1:0]  ADDR_HIGH_MASK  = 2'h3;
    localparam logic [7:0]  RST_BYTE        = 8'h00;
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ      = 2'h3;
endpackage : dcar_pkg

// File: dcar_cmp_if.sv
// dcar_cmp_if: stored match values from register file to comparator.
// assumes one clock domain; purely a bundle of levels.
`timescale 1ns/1ps
`default_nettype none
interface dcar_cmp_if;
    import dcar_pkg::*;
    logic [ADDR_W-1:0] addr_a;
    logic [DATA_W-1:0] data_a;
    logic [DATA_W-1:0] mask_a;
    logic              tag_a;
    logic [ADDR_W-1:0] addr_b;
    logic [ADDR_W-1:0] addr_c;
    modport regs (output addr_a, data_a, mask_a, tag_a, addr_b, addr_c);
    modport cmp  (input  addr_a, data_a, mask_a, tag_a, addr_b, addr_c);
endinterface : dcar_cmp_if
`default_nettype wire

// File: dcar_match.sv
// dcar_match: registered address match for the three comparators, data match for a only.
// assumes the monitored cpu buses are synchronous to hclk.
`timescale 1ns/1ps
`default_nettype none
module dcar_match
    import dcar_pkg::*;
(
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    dcar_cmp_if.cmp                   cfg,
    input  wire logic [ADDR_W-1:0]    cpu_addr,
    input  wire logic [DATA_W-1:0]    cpu_data,
    output logic      [NUM_CMP-1:0]   match
);
    wire logic [ADDR_W-1:0] stored [NUM_CMP];
    wire logic [NUM_CMP-1:0] addr_hit;
    wire logic              data_hit;
    assign stored[0] = cfg.addr_a;
    assign stored[1] = cfg.addr_b;
    assign stored[2] = cfg.addr_c;
    genvar g;
    generate
        for (g = 0; g < NUM_CMP; g++) begin : g_cmp
            // exact equality per bit, 0 expects low, 1 expects high
            assign addr_hit[g] = (cpu_addr == stored[g]);
        end
    endgenerate
    // mask 0 lets any bit pass; tag set drops data compare entirely
    assign data_hit = cfg.tag_a ||
        (((cpu_data ^ cfg.data_a) & cfg.mask_a) == '0);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            match <= '0;
        end else begin
            // b and c have no data path at all
            match <= {addr_hit[2:1], addr_hit[0] & data_hit};
        end
    end
endmodule : dcar_match
`default_nettype wire

// File: dcar_cpu_model.sv
// dcar_cpu_model: the monitored cpu address and data buses.
// assumes calls come just after a rising hclk edge; buses always driven.
`timescale 1ns/1ps
`default_nettype none
module dcar_cpu_model
    import dcar_pkg::*;
(
    input  wire logic                 hclk,
    output logic      [ADDR_W-1:0]    cpu_addr,
    output logic      [DATA_W-1:0]    cpu_data
);
    initial begin
        cpu_addr = '0;
        cpu_data = '0;
    end
    // a real cpu moves both buses together on the clock edge
    task automatic put(input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
        cpu_addr <= a;
        cpu_data <= d;
        @(posedge hclk);
    endtask : put
endmodule : dcar_cpu_model
`default_nettype wire

// File: debug_comparator_address_data_regs_tb.sv
// testbench for dcar_regs: window banking, arm lock and match paths.
// assumes zero-wait slave; hready is fed back from hreadyout.
`timescale 1ns/1ps
`default_nettype none
module debug_comparator_address_data_regs_tb;
    import dcar_pkg::*;
    logic              hclk = 1'b0;
    logic              hresetn = 1'b0;
    logic [31:0]       haddr = '0;
    logic [1:0]        htrans = '0;
    logic              hwrite = 1'b0;
    logic [31:0]       hwdata = '0;
    logic [31:0]       hrdata;
    logic              hreadyout;
    logic              hresp;
    logic [ADDR_W-1:0] cpu_addr;
    logic [DATA_W-1:0] cpu_data;
    logic [NUM_CMP-1:0] match;
    logic              armed;
    int                error_cnt = 0;
    int                check_count = 0;
    int                cycles = 0;
    always #12.5 hclk = ~hclk;
    dcar_regs u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .cpu_addr(cpu_addr),
        .cpu_data(cpu_data), .match(match), .armed(armed));
    dcar_cpu_model u_cpu (.hclk(hclk), .cpu_addr(cpu_addr),
        .cpu_data(cpu_data));
    task automatic close_out;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out
    // ceiling well above the roughly 170 cycles the run needs
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            error_cnt = error_cnt + 1;
            close_out();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [7:0] wd, output logic [31:0] rd);
        haddr  <= {22'h0, idx, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        logic [31:0] d;
        bus(1'b1, idx, v, d);
    endtask : wr
    task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
        logic [31:0] d;
        bus(1'b0, idx, 8'h00, d);
        check(d, {24'h0, e});
        check({31'h0, hresp}, 32'h0);
    endtask : rchk
    // reset values, then distinct address per bank; upper high bits stay 0
    task automatic t_banks;
        rchk(IDX_ADDR_MID, 8'h00);
        for (int s = 0; s < 4; s++) begin
            wr(IDX_CTRL_ONE, 8'(s));
            wr(IDX_ADDR_HIGH, 8'hfc | 8'(s));
            wr(IDX_ADDR_MID, 8'h10 + 8'(s));
        end
        for (int s = 0; s < 4; s++) begin
            wr(IDX_CTRL_ONE, 8'(s));
            rchk(IDX_ADDR_HIGH, s == 3 ? 8'h00 : 8'(s));
            rchk(IDX_ADDR_MID, s == 3 ? 8'h00 : 8'h10 + 8'(s));
        end
    endtask : t_banks
    // data registers exist behind select 00 only
    task automatic t_data_gate;
        wr(IDX_CTRL_ONE, 8'h00);
        wr(IDX_DATA_LOW, 8'h3c);
        wr(IDX_CTRL_ONE, 8'h01);
        wr(IDX_DATA_LOW, 8'hff);
        rchk(IDX_DATA_LOW, 8'h00);
        wr(IDX_CTRL_ONE, 8'h00);
        rchk(IDX_DATA_LOW, 8'h3c);
        rchk(8'h3f, 8'h00);
    endtask : t_data_gate
    // armed: reads still served, all writes to the window dropped except control one
    task automatic t_armed;
        wr(IDX_CTRL_ONE, 8'h80);
        // armed flips at the landing edge; look one edge later
        @(posedge hclk);
        check({31'h0, armed}, 32'h1);
        wr(IDX_ADDR_LOW, 8'h99);
        wr(IDX_DATA_LOW, 8'h99);
        rchk(IDX_ADDR_MID, 8'h10);
        rchk(IDX_ADDR_LOW, 8'h00);
        rchk(IDX_DATA_LOW, 8'h3c);
        wr(IDX_CTRL_ONE, 8'h00);
        @(posedge hclk);
        check({31'h0, armed}, 32'h0);
    endtask : t_armed
    task automatic mchk(input logic [17:0] a, input logic [15:0] d,
                        input logic [2:0] e);
        logic [31:0] s;
        u_cpu.put(a, d);
        @(posedge hclk);
        check({29'h0, match}, {29'h0, e});
        bus(1'b0, IDX_STATUS, 8'h00, s);
        check(s, {29'h0, e});
    endtask : mchk
    // a = 2a5c3, data 5a0f under mask f00f; b = 13c5a, c = 30001
    task automatic t_match;
        wr(IDX_ADDR_HIGH, 8'h02);
        wr(IDX_ADDR_MID, 8'ha5);
        wr(IDX_ADDR_LOW, 8'hc3);
        wr(IDX_DATA_HIGH, 8'h5a);
        wr(IDX_DATA_LOW, 8'h0f);
        wr(IDX_DMASK_HIGH, 8'hf0);
        wr(IDX_DMASK_LOW, 8'h0f);
        wr(IDX_CTRL_ONE, 8'h01);
        wr(IDX_ADDR_HIGH, 8'h01);
        wr(IDX_ADDR_MID, 8'h3c);
        wr(IDX_ADDR_LOW, 8'h5a);
        wr(IDX_CTRL_ONE, 8'h02);
        wr(IDX_ADDR_HIGH, 8'h03);
        wr(IDX_ADDR_MID, 8'h00);
        wr(IDX_ADDR_LOW, 8'h01);
        wr(IDX_CTRL_ONE, 8'h00);
        mchk(18'h2a5c3, 16'h50cf, 3'b001);
        mchk(18'h2a5c3, 16'h4a0f, 3'b000);
        mchk(18'h2a5c3, 16'h5a0e, 3'b000);
        mchk(18'h0a5c3, 16'h5a0f, 3'b000);
        mchk(18'h2a4c3, 16'h5a0f, 3'b000);
        mchk(18'h2a5c2, 16'h5a0f, 3'b000);
        mchk(18'h13c5a, 16'h0000, 3'b010);
        mchk(18'h30001, 16'hffff, 3'b100);
        wr(IDX_CMPA_CTRL, 8'h20);
        mchk(18'h2a5c3, 16'h4a0f, 3'b001);
    endtask : t_match
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_banks();
        t_data_gate();
        t_armed();
        t_match();
        close_out();
    end
endmodule : debug_comparator_address_data_regs_tb
`default_nettype wire
